//--- logic/cpfs_defs.svh
`ifndef CPFS_DEFS_SVH
`define CPFS_DEFS_SVH
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - any voltage, current or thermal fault stops gates and pulls fault flag low
// - voltage fault clears when mid-rail in window or both rails near ground
// - current fault clears only when sense drop is below 50mV
// - thermal fault holds until die temperature reads below 165C
// - pre-balance sources 93mA when mid-rail low, sinks 50mA when high
// - mid-rail inside window disables both currents and starts switching
// - fault flag released only after 36 in-window switching cycles
// - sense drop above 50mV flags overcurrent and drives fault flag low
// - overcurrent stops switching at once and enters timer-paced retry
// - overcurrent clears only when timer reaches 4V and drop below 50mV
// - out-of-window mid-rail raises fault during settling and normal running
// - window half-width follows the programming pin over 0.3V to 2.4V
// - programming pin tied to internal supply selects fixed 0.8V window
// - while switching, drives b and d are the complement of a and c, half duty
// - in shutdown all four gate drives are held low
//----------------------------------------------------------------------
`define CPFS_SETTLE_CYCLES 36
`define CPFS_CNT_W 6
`define CPFS_SYNC_W 11
`endif

//--- logic/cpfs_pkg.sv
`default_nettype none
package cpfs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BALANCE, ST_SETTLE, ST_RUN} cpfs_state_t;
  // synchronised comparator bundle
  typedef struct packed {
    logic in_window;
    logic mid_low;
    logic mid_high;
    logic rails_low;
    logic oc_trip;
    logic ot_trip;
    logic timer_4v;
    logic tied_supply;
    logic win_dflt;
    logic win_prog;
    logic uvlo;
  } cpfs_cmp_t;
endpackage
`default_nettype wire

//--- logic/cpfs_sync_if.sv
`default_nettype none
interface cpfs_sync_if;
  import cpfs_pkg::*;
  cpfs_cmp_t cmp;
  modport src (output cmp);
  modport dst (input cmp);
endinterface
`default_nettype wire

//--- logic/cpfs_sync.sv
`include "cpfs_defs.svh"
`default_nettype none
module cpfs_sync
  import cpfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`CPFS_SYNC_W-1:0] raw,
  cpfs_sync_if.src out
);
  typedef struct packed {
    logic [`CPFS_SYNC_W-1:0] s1;
    logic [`CPFS_SYNC_W-1:0] s2;
  } cpfs_sync_st_t;
  cpfs_sync_st_t st_q;
  cpfs_sync_st_t st_d;
  // two-stage synchroniser; first stage feeds only the second
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.s1 = raw;
      st_d.s2 = st_q.s1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign out.cmp = cpfs_cmp_t'(st_q.s2);
endmodule
`default_nettype wire

//--- logic/cpfs_supervisor.sv
`include "cpfs_defs.svh"
`default_nettype none
module cpfs_supervisor
  import cpfs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic IN_WINDOW_PROG,
  input wire logic IN_WINDOW_DFLT,
  input wire logic WINDOW_WIDTH_PIN_TIED,
  input wire logic MID_LOW,
  input wire logic MID_HIGH,
  input wire logic RAILS_NEAR_GND,
  input wire logic OC_TRIP,
  input wire logic OT_TRIP,
  input wire logic TIMER_AT_4V,
  input wire logic UVLO,
  output logic GATE_DRIVE_A,
  output logic GATE_DRIVE_B,
  output logic GATE_DRIVE_C,
  output logic GATE_DRIVE_D,
  output logic SOURCE_EN,
  output logic SINK_EN,
  output logic FAULT_N,
  output logic FAULT_N_OE,
  output logic RETRY_ACTIVE
);
  //----------------------------------------------------------------------
  // input synchronisation
  //----------------------------------------------------------------------
  cpfs_sync_if sif ();
  cpfs_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .ce(CE),
    .raw({IN_WINDOW_PROG, MID_LOW, MID_HIGH, RAILS_NEAR_GND, OC_TRIP, OT_TRIP,
          TIMER_AT_4V, WINDOW_WIDTH_PIN_TIED, IN_WINDOW_DFLT, IN_WINDOW_PROG, UVLO}),
    .out(sif.src)
  );
  cpfs_cmp_t c;
  assign c = sif.cmp;

  //----------------------------------------------------------------------
  // window selection and fault decode
  //----------------------------------------------------------------------
  function automatic logic win_ok(input cpfs_cmp_t k);
    // tied pin picks fixed window, else programmed window
    win_ok = k.tied_supply ? k.win_dflt : k.win_prog;
  endfunction

  typedef struct packed {
    cpfs_state_t st;
    logic vf;
    logic cf;
    logic tf;
    logic phase;
    logic fault;
    logic [`CPFS_CNT_W-1:0] cnt;
  } cpfs_st_t;
  cpfs_st_t q;
  cpfs_st_t d;
  logic ok_win;
  logic any_f;
  assign ok_win = win_ok(c);

  // refuse a settle count that the counter cannot reach
  if (`CPFS_SETTLE_CYCLES < 1 || `CPFS_SETTLE_CYCLES > (1 << `CPFS_CNT_W)) begin : g_cnt_check
    $error("settle count does not fit its counter");
  end

  //----------------------------------------------------------------------
  // sequencing and latched faults
  //----------------------------------------------------------------------
  always_comb begin
    d = q;
    any_f = 1'b0;
    if (CE) begin
      // voltage fault latches while switching or settling, clears on window or both rails low
      if ((q.st == ST_SETTLE || q.st == ST_RUN) && !ok_win) begin
        d.vf = 1'b1;
      end else if (ok_win || c.rails_low) begin
        d.vf = 1'b0;
      end
      if (c.oc_trip) begin
        d.cf = 1'b1;
      end else if (c.timer_4v) begin
        d.cf = 1'b0;
      end
      if (c.ot_trip) begin
        d.tf = 1'b1;
      end else begin
        d.tf = 1'b0;
      end
      any_f = d.vf | d.cf | d.tf | c.uvlo;
      unique case (q.st)
        ST_IDLE: begin
          d.phase = 1'b0;
          d.fault = 1'b1;
          if (!any_f) begin
            d.st = ST_BALANCE;
          end
        end
        ST_BALANCE: begin
          if (any_f) begin
            d.st = ST_IDLE;
          end else if (ok_win || c.rails_low) begin
            d.st = ST_SETTLE;
            d.cnt = '0;
          end
        end
        ST_SETTLE: begin
          d.phase = ~q.phase;
          if (any_f) begin
            d.st = ST_IDLE;
            d.phase = 1'b0;
          end else if (q.phase) begin
            if (q.cnt == `CPFS_CNT_W'(`CPFS_SETTLE_CYCLES - 1)) begin
              d.st = ST_RUN;
              d.fault = 1'b0;
            end else begin
              d.cnt = q.cnt + 1'b1;
            end
          end
        end
        ST_RUN: begin
          d.phase = ~q.phase;
          if (any_f) begin
            d.st = ST_IDLE;
            d.phase = 1'b0;
            d.fault = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '{st: ST_IDLE, vf: 1'b0, cf: 1'b0, tf: 1'b0, phase: 1'b0, fault: 1'b1, cnt: '0};
    end else begin
      q <= d;
    end
  end

  //----------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------
  logic sw_on;
  assign sw_on = (q.st == ST_SETTLE) || (q.st == ST_RUN);
  // complementary gate pairs, all low when not switching
  assign GATE_DRIVE_A = sw_on & q.phase;
  assign GATE_DRIVE_C = sw_on & q.phase;
  assign GATE_DRIVE_B = sw_on & ~q.phase;
  assign GATE_DRIVE_D = sw_on & ~q.phase;
  // pre-balance currents only while balancing
  assign SOURCE_EN = (q.st == ST_BALANCE) && c.mid_low && !ok_win;
  assign SINK_EN = (q.st == ST_BALANCE) && c.mid_high && !ok_win;
  assign FAULT_N = 1'b0;
  assign FAULT_N_OE = q.fault | q.vf | q.cf | q.tf;
  assign RETRY_ACTIVE = q.cf;

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------
  a_gates_off_idle: assert property (@(posedge REF_CLK) disable iff (RST)
    (q.st == ST_IDLE || q.st == ST_BALANCE) |-> !(GATE_DRIVE_A | GATE_DRIVE_B | GATE_DRIVE_C | GATE_DRIVE_D))
    else $error("gate active while not switching");
  a_gate_complement: assert property (@(posedge REF_CLK) disable iff (RST)
    sw_on |-> (GATE_DRIVE_B == !GATE_DRIVE_A) && (GATE_DRIVE_D == !GATE_DRIVE_C))
    else $error("gates not complementary");
  a_fault_stops: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && sw_on && c.ot_trip) |=> (q.st == ST_IDLE) && FAULT_N_OE)
    else $error("fault did not stop switching");
  a_oc_latch: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && c.oc_trip) |=> q.cf && FAULT_N_OE)
    else $error("overcurrent not flagged");
  a_oc_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    (q.cf && !c.timer_4v) |=> q.cf)
    else $error("overcurrent cleared before timer");
  a_no_both_cur: assert property (@(posedge REF_CLK) disable iff (RST)
    (SOURCE_EN || SINK_EN) |-> !(SOURCE_EN && SINK_EN) && !sw_on)
    else $error("pre-balance current during switching");
  a_ot_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && c.ot_trip) |=> q.tf && FAULT_N_OE)
    else $error("thermal fault not held");
  a_vf_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    (q.vf && !ok_win && !c.rails_low) |=> q.vf)
    else $error("voltage fault cleared outside window");
  a_bal_start: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && q.st == ST_BALANCE && ok_win && !c.uvlo && !q.cf && !c.oc_trip && !c.ot_trip)
    |=> sw_on && !SOURCE_EN && !SINK_EN)
    else $error("balanced rail did not start switching");
  a_settle_holds: assert property (@(posedge REF_CLK) disable iff (RST)
    (q.st == ST_SETTLE) |-> q.fault)
    else $error("fault released during settling");
  a_win_fault: assert property (@(posedge REF_CLK) disable iff (RST)
    (CE && sw_on && !ok_win) |=> q.vf && !sw_on)
    else $error("window loss not faulted");
  c_reach_run: cover property (@(posedge REF_CLK) q.st == ST_SETTLE ##1 q.st == ST_RUN);
  c_oc_retry: cover property (@(posedge REF_CLK) q.cf ##1 !q.cf);
  c_balance_src: cover property (@(posedge REF_CLK) SOURCE_EN);
  c_win_fault: cover property (@(posedge REF_CLK) sw_on ##1 q.vf);
  c_ce_hold: cover property (@(posedge REF_CLK) !CE && sw_on);
endmodule
`default_nettype wire

//--- testbench/cpfs_plant.sv
`default_nettype none
//------------------
// rail and timer model
//------------------
module cpfs_plant (
  input wire logic clk,
  input wire logic load,
  input wire logic [3:0] lvl,
  input wire logic src,
  input wire logic snk,
  input wire logic retry,
  output logic in_win,
  output logic low,
  output logic high,
  output logic t4v
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mid = 4'h8;
  logic [3:0] tmr = 4'h0;
  // node set by preload, else moved only by pre-balance currents; no load drawn
  always @(posedge clk) begin
    if (load)
      mid <= lvl;
    else if (src && mid != 4'hf)
      mid <= mid + 4'h1;
    else if (snk && mid != 4'h0)
      mid <= mid - 4'h1;
    tmr <= !retry ? 4'h0 : tmr + 4'(tmr != 4'hc);
  end
  // comparator views of the node and timer
  assign low = mid < 4'h7;
  assign high = mid > 4'h9;
  assign in_win = !low && !high;
  assign t4v = tmr == 4'hc;
endmodule
`default_nettype wire

//--- testbench/cpfs_supervisor_tb.sv
`default_nettype none
//------------------
// supervisor bench
//------------------
module cpfs_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, tied = 0, bad = 0, gnd = 0, oc = 0, ot = 0, ld = 1, ce = 1, uv = 0;
  logic [3:0] lvl = 4'h2;
  logic win, lo, hi, t4v, ga, gb, gc, gd, src, snk, fn, oe, ra;
  int fail_count = 0, n_compared = 0, waited;
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  cpfs_supervisor dut (.REF_CLK(clk), .RST(rst), .CE(ce), .IN_WINDOW_PROG(win && !bad), .IN_WINDOW_DFLT(win),
    .WINDOW_WIDTH_PIN_TIED(tied), .MID_LOW(lo), .MID_HIGH(hi), .RAILS_NEAR_GND(gnd), .OC_TRIP(oc),
    .OT_TRIP(ot), .TIMER_AT_4V(t4v), .UVLO(uv), .GATE_DRIVE_A(ga), .GATE_DRIVE_B(gb), .GATE_DRIVE_C(gc),
    .GATE_DRIVE_D(gd), .SOURCE_EN(src), .SINK_EN(snk), .FAULT_N(fn), .FAULT_N_OE(oe), .RETRY_ACTIVE(ra));
  cpfs_plant plant (.clk(clk), .load(ld), .lvl(lvl), .src(src), .snk(snk), .retry(ra), .in_win(win),
    .low(lo), .high(hi), .t4v(t4v));
  // compare, count and close
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d bad %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait: 0 gates busy, 1 flag pulled, 2 retry
  task automatic wait_on(input int sel, input logic v);
    logic s;
    waited = 0;
    do begin
      cyc(1);
      waited++;
      s = sel == 0 ? ga | gb : sel == 1 ? oe : ra;
      if (waited > 400) begin
        $display("BAD wait%0d exp %b got %b", sel, v, s);
        fail_count++;
        report_and_stop;
      end
    end while (s !== v);
  endtask
  // shutdown, preload rail, pre-balance, switch, settle
  task automatic t_start(input logic [3:0] l, input logic up);
    @(posedge clk) {rst, ld, lvl} <= {2'b11, l};
    cyc(5);
    chk("gates_off", 8'h0, {ga, gb, gc, gd});
    chk("flag_oe", 8'h1, oe);
    @(posedge clk) {rst, ld} <= 2'b00;
    cyc(3);
    chk("source", up, src);
    chk("sink", !up, snk);
    wait_on(0, 1);
    chk("bal_off", 8'h0, {src, snk});
    for (int i = 0; i < 6; i++) begin
      chk("phase", i[0] ? 8'ha : 8'h5, {ga, gb, gc, gd});
      cyc(1);
    end
    wait_on(1, 0);
    chk("settle", 8'h1, waited + 6 >= 71 && waited + 6 <= 73);
    chk("flag_data", 8'h0, fn);
    $display("start %h done", l);
  endtask
  // short then held overcurrent
  task automatic t_oc;
    @(posedge clk) oc <= 1;
    wait_on(0, 0);
    chk("oc_stop", 8'h1, waited <= 3);
    chk("oc_flag", 8'h1, oe);
    chk("oc_retry", 8'h1, ra);
    @(posedge clk) oc <= 0;
    wait_on(2, 0);
    chk("oc_paced", 8'h1, waited >= 8);
    wait_on(1, 0);
    @(posedge clk) oc <= 1;
    cyc(30);
    chk("oc_hold", 8'h1, ra);
    @(posedge clk) oc <= 0;
    wait_on(2, 0);
    chk("oc_clear", 8'h1, waited <= 5);
    wait_on(1, 0);
    $display("overcurrent done");
  endtask
  // thermal fault held while hot
  task automatic t_ot;
    @(posedge clk) ot <= 1;
    wait_on(0, 0);
    cyc(30);
    chk("ot_hold", 8'h1, {ga, gb, gc, gd, oe});
    @(posedge clk) ot <= 0;
    wait_on(1, 0);
    $display("thermal done");
  endtask
  // window loss, rails-near-ground clear, default window
  task automatic t_win;
    @(posedge clk) bad <= 1;
    wait_on(0, 0);
    chk("win_flag", 8'h1, oe);
    cyc(20);
    chk("win_held", 8'h0, {ga, gb, gc, gd});
    @(posedge clk) gnd <= 1;
    wait_on(0, 1);
    @(posedge clk) {gnd, bad} <= 2'b00;
    wait_on(1, 0);
    @(posedge clk) {tied, bad} <= 2'b11;
    cyc(20);
    chk("dflt_win", 8'h0, oe);
    @(posedge clk) tied <= 0;
    wait_on(1, 1);
    @(posedge clk) bad <= 0;
    wait_on(1, 0);
    $display("window done");
  endtask
  // clock enable low freezes the gate phase
  task automatic t_freeze;
    logic [3:0] g, h;
    @(posedge clk) ce <= 0;
    cyc(3);
    g = {ga, gb, gc, gd};
    h = ~g;
    cyc(4);
    chk("ce_freeze", g, {ga, gb, gc, gd});
    @(posedge clk) ce <= 1;
    cyc(1);
    chk("ce_resume", h, {ga, gb, gc, gd});
    wait_on(1, 0);
    $display("freeze done");
  endtask
  // supply undervoltage stops switching
  task automatic t_uvlo;
    @(posedge clk) uv <= 1;
    wait_on(0, 0);
    chk("uv_stop", 8'h1, waited <= 3);
    chk("uv_flag", 8'h1, oe);
    cyc(10);
    chk("uv_held", 8'h0, {ga, gb, gc, gd});
    @(posedge clk) uv <= 0;
    wait_on(1, 0);
    $display("undervoltage done");
  endtask
  initial begin
    t_start(4'h2, 1'b1);
    t_start(4'he, 1'b0);
    t_oc;
    t_ot;
    t_freeze;
    t_uvlo;
    t_win;
    report_and_stop;
  end
endmodule
`default_nettype wire
